// File: hw/cmc_pkg.sv
// package of constants and types for the configuration memory soft error checker
package cmc_pkg;

	// ==========================================================
	// configuration memory geometry and crc
	localparam int          CMC_ADDR_W      = 12;
	localparam logic [11:0] CMC_LAST_ADDR   = 12'hFFF;
	localparam int          CMC_CRC_W       = 32;
	localparam logic [31:0] CMC_CRC_POLY    = 32'h04C11DB7;
	localparam logic [31:0] CMC_CRC_INIT    = 32'hFFFFFFFF;

	// ==========================================================
	// check clock divider: system clock 200 MHz, check clock 50 MHz
	// a fast check clock keeps one pass near 16k system cycles; slower rates only stretch it
	localparam int          CMC_SYS_MHZ     = 200;
	localparam int          CMC_CHK_KHZ     = 50000;
	localparam int          CMC_DIV_CYCLES  = (CMC_SYS_MHZ * 1000) / CMC_CHK_KHZ;
	localparam int          CMC_DIV_W       = 8;
	localparam logic [7:0]  CMC_DIV_LAST    = 8'(CMC_DIV_CYCLES - 1);
	localparam logic [7:0]  CMC_DIV_HALF    = 8'(CMC_DIV_CYCLES / 2);

	// ==========================================================
	// checker states, gray along idle -> fetch -> compare
	typedef enum logic [1:0] {
		CMC_IDLE    = 2'b00,
		CMC_FETCH   = 2'b01,
		CMC_COMPARE = 2'b11
	} cmc_state_e;

endpackage

// File: hw/cmc_crc_if.sv
// interface carrying the serial configuration bit stream into the crc engine
`timescale 1ns/1ps
`default_nettype none
interface cmc_crc_if;
	logic        clear;
	logic        bit_valid;
	logic        bit_data;
	logic [31:0] crc;

	modport ctrl (output clear, output bit_valid, output bit_data, input crc);
	modport eng  (input clear, input bit_valid, input bit_data, output crc);
endinterface
`default_nettype wire

// File: hw/cmc_crc_engine.sv
// serial crc accumulator over the fetched configuration bits
`timescale 1ns/1ps
`default_nettype none
module cmc_crc_engine
	import cmc_pkg::*;
(
	// clock and reset
	input  wire logic CLK_SYS,
	input  wire logic NRST,
	// bit stream
	cmc_crc_if.eng    crc_io
);
	logic [31:0] crc;
	logic [31:0] next_crc;
	logic        fb;

	// ==========================================================
	// one bit per valid strobe, msb-first shift
	always_comb begin
		fb = crc[31] ^ crc_io.bit_data;
		next_crc = crc;
		if (crc_io.clear) begin
			next_crc = CMC_CRC_INIT;
		end else if (crc_io.bit_valid) begin
			next_crc = {crc[30:0], 1'b0} ^ (fb ? CMC_CRC_POLY : 32'h00000000);
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			crc <= CMC_CRC_INIT;
		end else begin
			crc <= next_crc;
		end
	end

	assign crc_io.crc = crc;
endmodule
`default_nettype wire

// File: hw/cmc_checker.sv
// configuration memory soft error checker, basic and one-shot variants
`timescale 1ns/1ps
`default_nettype none
module cmc_checker
	import cmc_pkg::*;
(
	// system clock and reset (reset stands for reconfiguration)
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	// configuration image: fuse, expected crc, memory read port
	input  wire logic        ONE_SHOT_FUSE,
	input  wire logic        EXP_CRC_LOAD,
	input  wire logic [31:0] EXP_CRC_DATA,
	output logic [11:0]      CFG_ADDR,
	input  wire logic        CFG_BIT,
	input  wire logic        CFG_IS_RAM,
	// user fabric inputs
	input  wire logic        CHECK_ENABLE,
	input  wire logic        CHECK_START,
	input  wire logic        FORCE_ERROR_N,
	// user fabric outputs
	output logic             GATED_CHECK_CLOCK,
	output logic             CHECK_DONE,
	output logic             CHECK_IN_PROGRESS,
	output logic             CHECK_ERROR_FLAG
);
	// ==========================================================
	// pin synchronisers: user inputs come from another domain
	logic [1:0] en_s, st_s, fe_s, fu_s;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			en_s <= 2'b00;
			st_s <= 2'b00;
			fe_s <= 2'b11;
			fu_s <= 2'b00;
		end else begin
			en_s <= {en_s[0], CHECK_ENABLE};
			st_s <= {st_s[0], CHECK_START};
			fe_s <= {fe_s[0], FORCE_ERROR_N};
			fu_s <= {fu_s[0], ONE_SHOT_FUSE};
		end
	end

	// ==========================================================
	// check clock divider: enable pulse plus a square check clock
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic       chk_tick;
	logic       chk_clk;
	logic       next_chk_clk;

	always_comb begin
		chk_tick     = (div_cnt == CMC_DIV_LAST);
		next_div_cnt = chk_tick ? 8'h00 : div_cnt + 8'h01;
		next_chk_clk = (next_div_cnt < CMC_DIV_HALF);
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			div_cnt <= 8'h00;
			chk_clk <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			chk_clk <= next_chk_clk;
		end
	end

	// ==========================================================
	// mode and effective controls; the fuse is caught after reset release
	logic one_shot;
	logic next_one_shot;
	logic fuse_taken;
	logic next_fuse_taken;
	logic [1:0] fuse_age;
	logic [1:0] next_fuse_age;
	logic os_fired;
	logic next_os_fired;
	logic enable;
	logic start;
	logic force_err;

	always_comb begin
		// the fuse is read once, on the first edge at which its synchroniser holds a real sample
		next_fuse_age   = {fuse_age[0], 1'b1};
		next_fuse_taken = fuse_taken | fuse_age[1];
		next_one_shot   = fuse_taken ? one_shot : fu_s[1];
		// one-shot ignores every user input: runs one pass, no force, enabled once the fuse is taken
		enable    = one_shot ? fuse_taken : en_s[1];
		start     = one_shot ? (fuse_taken && !os_fired) : st_s[1];
		force_err = one_shot ? 1'b0 : !fe_s[1];
	end

	// ==========================================================
	// expected crc storage, written on any cycle with EXP_CRC_LOAD high
	logic [31:0] exp_crc;
	logic [31:0] next_exp_crc;

	always_comb begin
		next_exp_crc = EXP_CRC_LOAD ? EXP_CRC_DATA : exp_crc;
	end

	// ==========================================================
	// pass sequencer
	cmc_crc_if  crc_io ();
	cmc_state_e state;
	cmc_state_e next_state;
	logic [11:0] addr;
	logic [11:0] next_addr;
	logic        done;
	logic        next_done;
	logic        busy;
	logic        next_busy;
	logic        err;
	logic        next_err;

	always_comb begin
		next_state    = state;
		next_addr     = addr;
		next_done     = done;
		next_busy     = busy;
		next_err      = err;
		next_os_fired = os_fired;
		crc_io.clear     = 1'b0;
		crc_io.bit_valid = 1'b0;
		crc_io.bit_data  = CFG_BIT;
		if (!enable) begin
			// disarm: abort any pass, clear done and error
			next_state = CMC_IDLE;
			next_done  = 1'b0;
			next_busy  = 1'b0;
			next_err   = 1'b0;
		end else if (chk_tick) begin
			unique case (state)
				CMC_IDLE: begin
					if (start) begin
						next_state    = CMC_FETCH;
						next_addr     = 12'h000;
						next_busy     = 1'b1;
						next_done     = 1'b0;
						next_os_fired = 1'b1;
						crc_io.clear  = 1'b1;
					end
				end
				CMC_FETCH: begin
					// every address is walked; ram-backed cells are skipped
					crc_io.bit_valid = !CFG_IS_RAM;
					next_addr        = addr + 12'h001;
					if (addr == CMC_LAST_ADDR) begin
						next_state = CMC_COMPARE;
					end
				end
				CMC_COMPARE: begin
					next_state = CMC_IDLE;
					next_busy  = 1'b0;
					next_done  = 1'b1;
					// only sets, never clears: sticky
					if (crc_io.crc != exp_crc) begin
						next_err = 1'b1;
					end
				end
				default: next_state = CMC_IDLE;
			endcase
			if (force_err) begin
				next_err = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			state      <= CMC_IDLE;
			addr       <= 12'h000;
			done       <= 1'b0;
			busy       <= 1'b0;
			err        <= 1'b0;
			os_fired   <= 1'b0;
			one_shot   <= 1'b0;
			fuse_taken <= 1'b0;
			fuse_age   <= 2'b00;
			exp_crc    <= 32'h00000000;
		end else begin
			state      <= next_state;
			addr       <= next_addr;
			done       <= next_done;
			busy       <= next_busy;
			err        <= next_err;
			os_fired   <= next_os_fired;
			one_shot   <= next_one_shot;
			fuse_taken <= next_fuse_taken;
			fuse_age   <= next_fuse_age;
			exp_crc    <= next_exp_crc;
		end
	end

	cmc_crc_engine u_crc (
		.CLK_SYS (CLK_SYS),
		.NRST    (NRST),
		.crc_io  (crc_io.eng)
	);

	// ==========================================================
	// outputs; gated clock is a combinational AND of registered chk_clk, en_s[1] and !one_shot
	always_comb begin
		CFG_ADDR          = addr;
		CHECK_DONE        = done;
		CHECK_IN_PROGRESS = busy;
		CHECK_ERROR_FLAG  = err;
		GATED_CHECK_CLOCK = chk_clk && en_s[1] && !one_shot;
	end

	// ==========================================================
	// assertions
	// named steps of a pass; some of the pass properties are built from them
	sequence s_start_tick;
		enable && chk_tick && state == CMC_IDLE && start;
	endsequence
	sequence s_fetch_tick;
		enable && chk_tick && state == CMC_FETCH;
	endsequence
	sequence s_compare_tick;
		enable && chk_tick && state == CMC_COMPARE;
	endsequence

	a_busy_rise: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_start_tick |=> CHECK_IN_PROGRESS)
		else $error("busy did not rise after start");
	a_done_clear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(!enable) |=> !CHECK_DONE)
		else $error("done not cleared by enable low");
	a_err_sticky: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CHECK_ERROR_FLAG && enable) |=> CHECK_ERROR_FLAG)
		else $error("error cleared while enabled");
	a_err_clear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(!enable) |=> !CHECK_ERROR_FLAG)
		else $error("error not cleared by enable low");
	a_force_err: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(enable && chk_tick && force_err) |=> CHECK_ERROR_FLAG)
		else $error("force did not set error");
	a_mismatch_err: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(enable && chk_tick && state == CMC_COMPARE && crc_io.crc != exp_crc) |=> CHECK_ERROR_FLAG)
		else $error("mismatch missed");
	a_match_quiet: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(enable && chk_tick && state == CMC_COMPARE && crc_io.crc == exp_crc && !CHECK_ERROR_FLAG
			&& !force_err) |=> !CHECK_ERROR_FLAG)
		else $error("error on matching crc");
	a_pass_end: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_compare_tick |=> (CHECK_DONE && !CHECK_IN_PROGRESS))
		else $error("pass end outputs wrong");
	a_ram_skip: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CFG_IS_RAM) |-> !crc_io.bit_valid)
		else $error("ram cell fed to crc");
	a_one_shot_io: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(one_shot) |-> !GATED_CHECK_CLOCK)
		else $error("one-shot drives gated clock");

	// pass-level checks: fetch order, full coverage and the single one-shot pass
	a_start_clears: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_start_tick |=> (!CHECK_DONE && CFG_ADDR == 12'h000 && state == CMC_FETCH))
		else $error("start did not open a pass");
	a_fetch_feed: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_fetch_tick |-> (crc_io.bit_valid == !CFG_IS_RAM && crc_io.bit_data == CFG_BIT))
		else $error("fetched bit not fed to crc");
	a_addr_walk: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_fetch_tick |=> (CFG_ADDR == $past(CFG_ADDR) + 12'h001))
		else $error("address skipped during fetch");
	a_fetch_stay: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(enable && chk_tick && state == CMC_FETCH && CFG_ADDR != CMC_LAST_ADDR) |=> (state == CMC_FETCH))
		else $error("pass left before the last address");
	a_last_addr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(enable && chk_tick && state == CMC_FETCH && CFG_ADDR == CMC_LAST_ADDR)
			|=> (state == CMC_COMPARE && CHECK_IN_PROGRESS))
		else $error("pass did not stop at the last address");
	a_busy_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(state == CMC_FETCH || state == CMC_COMPARE) |-> CHECK_IN_PROGRESS)
		else $error("busy low during a pass");
	a_done_busy_excl: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!(CHECK_DONE && CHECK_IN_PROGRESS))
		else $error("done and busy together");
	a_compare_idle: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_compare_tick |=> (state == CMC_IDLE))
		else $error("pass did not return to idle");
	a_one_shot_once: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(one_shot && os_fired && state == CMC_IDLE) |=> (state == CMC_IDLE))
		else $error("one-shot started a second pass");
endmodule
`default_nettype wire

// File: test/cmc_cfg_mem_model.sv
// partner model: configuration memory image seen by the checker's read port
`timescale 1ns/1ps
`default_nettype none
module cmc_cfg_mem_model (
	// read port
	input  wire logic [11:0] CFG_ADDR,
	output logic             CFG_BIT,
	output logic             CFG_IS_RAM
);
	// pattern mixes low and high address bits, so skipped or reordered reads change the crc
	function automatic logic bit_at(input logic [11:0] a);
		return a[0] ^ a[3] ^ a[7] ^ a[11];
	endfunction
	// one page of the image holds block ram contents
	function automatic logic ram_at(input logic [11:0] a);
		return a[11:8] == 4'hA;
	endfunction
	// combinational read in the same cycle as the address
	assign CFG_BIT    = bit_at(CFG_ADDR);
	assign CFG_IS_RAM = ram_at(CFG_ADDR);
endmodule
`default_nettype wire

// File: test/config_memory_soft_error_crc_check_tb_top.sv
// self-checking testbench of the configuration memory soft error checker
`timescale 1ns/1ps
`default_nettype none
module config_memory_soft_error_crc_check_tb_top
	import cmc_pkg::*;
;
	// ==========================================================
	// signals
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        fuse = 1'b0;
	logic        ld = 1'b0;
	logic [31:0] ld_data = 32'h0;
	logic [11:0] addr;
	logic        cfg_bit;
	logic        cfg_ram;
	logic        en = 1'b0;
	logic        start = 1'b0;
	logic        frc_n = 1'b1;
	logic        gclk;
	logic        done;
	logic        busy;
	logic        err;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [31:0] good;

	cmc_cfg_mem_model mem (.CFG_ADDR(addr), .CFG_BIT(cfg_bit), .CFG_IS_RAM(cfg_ram));
	cmc_checker DUT (
		.CLK_SYS(clk_sys), .NRST(nrst), .ONE_SHOT_FUSE(fuse), .EXP_CRC_LOAD(ld), .EXP_CRC_DATA(ld_data),
		.CFG_ADDR(addr), .CFG_BIT(cfg_bit), .CFG_IS_RAM(cfg_ram), .CHECK_ENABLE(en), .CHECK_START(start),
		.FORCE_ERROR_N(frc_n), .GATED_CHECK_CLOCK(gclk), .CHECK_DONE(done), .CHECK_IN_PROGRESS(busy),
		.CHECK_ERROR_FLAG(err));

	// ==========================================================
	// clock, timeout and common tasks
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// four passes of 4097 check ticks at 4 cycles each take about 66k cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic f);
		nrst = 1'b0;
		fuse = f;
		repeat (12) @(negedge clk_sys);
		nrst = 1'b1;
		@(negedge clk_sys);
	endtask
	// expected crc over the image, ram page skipped
	function automatic logic [31:0] ref_crc();
		logic [31:0] c;
		c = CMC_CRC_INIT;
		for (int a = 0; a < 4096; a++) begin
			if (!mem.ram_at(12'(a)))
				c = {c[30:0], 1'b0} ^ ((c[31] ^ mem.bit_at(12'(a))) ? CMC_CRC_POLY : 32'h0);
		end
		return c;
	endfunction
	// waits on one output (0 gated clock, 1 busy, 2 done, 3 error) with a bound
	// the bound running out shows as a mismatch in the check that follows
	task automatic wait_flag(input logic [1:0] sel, input int lim);
		logic [3:0] v;
		for (int i = 0; i < lim; i++) begin
			v = {err, done, busy, gclk};
			if (v[sel] === 1'b1)
				break;
			@(negedge clk_sys);
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_idle_and_gate();
		check({gclk, done, busy, err}, 4'h0);
		repeat (200) begin
			@(negedge clk_sys);
			check(gclk, 1'b0);
		end
		en = 1'b1;
		wait_flag(2'd0, 200);
		check(gclk, 1'b1);
	endtask
	task automatic t_pass(input logic [31:0] exp, input logic want_err, input logic was_done);
		ld_data = exp;
		ld = 1'b1;
		@(negedge clk_sys);
		ld = 1'b0;
		start = 1'b1;
		check(done, was_done);
		wait_flag(2'd1, 300);
		check(busy, 1'b1);
		check(done, 1'b0);
		start = 1'b0;
		wait_flag(2'd2, 20000);
		check({done, busy, err}, {2'b10, want_err});
	endtask
	task automatic t_disable();
		en = 1'b0;
		repeat (4) @(negedge clk_sys);
		check({done, err, gclk}, 3'h0);
		en = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(err, 1'b0);
	endtask
	task automatic t_force();
		frc_n = 1'b0;
		wait_flag(2'd3, 300);
		check(err, 1'b1);
		frc_n = 1'b1;
		repeat (200) @(negedge clk_sys);
		check(err, 1'b1);
	endtask
	// enable stays high and force is held low: one-shot must ignore both
	task automatic t_one_shot();
		en = 1'b1;
		do_reset(1'b1);
		ld_data = good;
		ld = 1'b1;
		@(negedge clk_sys);
		ld = 1'b0;
		frc_n = 1'b0;
		wait_flag(2'd1, 400);
		check({busy, gclk}, 2'b10);
		wait_flag(2'd2, 20000);
		check({done, busy, err}, 3'h4);
		repeat (100) begin
			@(negedge clk_sys);
			check(gclk, 1'b0);
		end
		check({done, busy, err}, 3'h4);
		frc_n = 1'b1;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		good = ref_crc();
		do_reset(1'b0);
		t_idle_and_gate();
		t_pass(good ^ 32'h1, 1'b1, 1'b0);
		t_pass(good, 1'b1, 1'b1);
		t_disable();
		t_pass(good, 1'b0, 1'b0);
		t_force();
		t_one_shot();
		test_done();
	end
endmodule
`default_nettype wire
